// File: jad_params.svh
// constants for the jack accessory detector: offsets, fields, resets, timing
`ifndef JAD_PARAMS_SVH
`define JAD_PARAMS_SVH

// ==========================================================
// register byte offsets
`define JAD_OFS_CTRL 8'h00
`define JAD_OFS_CFG 8'h04
`define JAD_OFS_STATUS 8'h08
`define JAD_OFS_EVENT 8'h0C
`define JAD_OFS_MASK 8'h10
`define JAD_OFS_BTHR 8'h14

// ==========================================================
// field positions
`define JAD_CTRL_SYS 0
`define JAD_CTRL_DET 1
`define JAD_CTRL_TYPE_EN 2
`define JAD_CTRL_TYPE_FRC 3
`define JAD_CTRL_ORD_EN 4
`define JAD_CTRL_ORD_FRC 5
`define JAD_CTRL_HP_EN 6
`define JAD_CTRL_MIC 7
`define JAD_EV_INS 0
`define JAD_EV_REM 1
`define JAD_EV_DONE 2
`define JAD_EV_PRESS 3
`define JAD_EV_REL 7
`define JAD_EV_W 11

// ==========================================================
// reset values
`define JAD_CTRL_RST 8'h14
`define JAD_CFG_RST 19'h00082
`define JAD_MASK_RST 11'h000
`define JAD_BTHR_RST 32'hC0804000

// ==========================================================
// timing
`define JAD_CLK_NS 20
`define JAD_MS_NS 1000000
`define JAD_LAT3_BASE_MS 10'd32
`define JAD_BTN_MIN_MS 9'd2
`define JAD_BTN_MAX_MS 9'd500
`define JAD_BTN_MAX_CFG 8'hFA

// ==========================================================
// debounce tables in ms
`define JAD_INS_DEB0 10'd5
`define JAD_INS_DEB1 10'd10
`define JAD_INS_DEB2 10'd20
`define JAD_INS_DEB3 10'd50
`define JAD_INS_DEB4 10'd100
`define JAD_INS_DEB5 10'd200
`define JAD_INS_DEB6 10'd500
`define JAD_INS_DEB7 10'd1
`define JAD_REM_DEB0 10'd1
`define JAD_REM_DEB1 10'd5
`define JAD_REM_DEB2 10'd10
`define JAD_REM_DEB3 10'd20

// ==========================================================
// thresholds in ohms
`define JAD_TYPE_THR0 14'd200
`define JAD_TYPE_THR1 14'd500
`define JAD_TYPE_THR2 14'd750
`define JAD_TYPE_THR3 14'd1000
`define JAD_HP_THR0 14'd1000
`define JAD_HP_THR1 14'd2500
`define JAD_HP_THR2 14'd5000
`define JAD_HP_THR3 14'd10000

`endif

// File: jad_pkg.sv
// types shared by the jack accessory detector
package jad_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_TYPE = 6'b000010,
        ST_ORDER = 6'b000100,
        ST_LAT = 6'b001000,
        ST_BTN = 6'b010000,
        ST_BMEAS = 6'b100000
    } jad_state_e;

    // answers from the analog measurement front end
    typedef struct packed {
        logic res_valid;
        logic [13:0] res_ohm;
        logic order_valid;
        logic order_sleeve_mic;
        logic load_valid;
        logic [13:0] load_ohm;
        logic btn_valid;
        logic [7:0] btn_code;
    } jad_meas_s;

    // measurement requests, held until the matching valid
    typedef struct packed {
        logic type_req;
        logic order_req;
        logic btn_req;
    } jad_req_s;

endpackage

// File: jad_accessory_detect.sv
// jack accessory detector: debounce, classification, buttons, mic supply, ahb regs
//
// Overview of operation
// - debounced insertion/removal set their events; presence status follows the jack
// - detect-complete comes 32/64 ms times 2^rate after insertion
// - insertion debounce from 3-bit field, 20 ms default
// - removal debounce from 2-bit field, 1 ms default
// - mask bit only removes its event from the interrupt
// - one interrupt line, high while any unmasked event is set
// - events are individually maskable and cleared by writing 1
// - with type detect on, resistance above threshold gives 4-pole
// - type threshold 200, 500 default, 750, 1000 ohm
// - type status 0 is 3-pole, 1 is 4-pole, valid after complete
// - complete raised once both type and order are final
// - with type detect off, force bit sets the type
// - order detect automatic when enabled, else force bit picks order
// - with load test on, load at or above threshold is headphone
// - load threshold 1.0/2.5/5.0/10.0 kohm, result held readable
// - button config enables polling and sets 2..500 ms period
// - four thresholds split the code into A, D, B, C, mic
// - press and release events per button, last code readable
// - while a button is held further presses are ignored
// - 4-pole complete turns the mic supply on; host bit too
// - removal turns off, discharges and isolates the mic supply
// - status bit shows the mic supply rail is up
// - jack sensing runs only with system active and detector on
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "jad_params.svh"

module jad_accessory_detect #(
    parameter int TICK_CYCLES = `JAD_MS_NS / `JAD_CLK_NS
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic JACK_SENSE,
    input wire logic MIC_RAIL_OK,
    input wire jad_pkg::jad_meas_s MEAS,
    output jad_pkg::jad_req_s MEAS_REQ,
    output logic MIC_SUPPLY_ENABLE,
    output logic MIC_DISCHARGE,
    output logic MIC_ISOLATE,
    output logic IRQ
);
    import jad_pkg::*;

    // ==========================================================
    // registers
    jad_state_e st_q, st_d;
    logic [7:0] ctrl_q;
    logic [18:0] cfg_q;
    logic [10:0] ev_q, mask_q;
    logic [31:0] bthr_q;
    logic [31:0] rdata_q;
    logic [7:0] dp_addr_q;
    logic dp_wr_q;
    logic [15:0] tick_cnt_q;
    logic sense_q, present_q;
    logic [9:0] deb_cnt_q, lat_cnt_q;
    logic [8:0] poll_cnt_q;
    logic type_q, order_q, hp_q, mic_auto_q, mic_up_q, dis_q;
    logic [7:0] btn_code_q;
    logic [3:0] held_q;

    // ==========================================================
    // bus decode
    wire logic ap_valid = HSEL & HREADY & HTRANS[1];
    wire logic [7:0] ap_addr = HADDR[7:0];
    wire logic addr_hi_ok = (HADDR[31:8] == 24'h000000);
    wire logic wr_ctrl = dp_wr_q & (dp_addr_q == `JAD_OFS_CTRL);
    wire logic wr_cfg = dp_wr_q & (dp_addr_q == `JAD_OFS_CFG);
    wire logic wr_ev = dp_wr_q & (dp_addr_q == `JAD_OFS_EVENT);
    wire logic wr_mask = dp_wr_q & (dp_addr_q == `JAD_OFS_MASK);
    wire logic wr_bthr = dp_wr_q & (dp_addr_q == `JAD_OFS_BTHR);

    wire logic [12:0] status_w = {btn_code_q, mic_up_q, hp_q, order_q, type_q, present_q};
    wire logic [31:0] rd_mux =
        (!addr_hi_ok) ? 32'h00000000 :
        (ap_addr == `JAD_OFS_CTRL) ? {24'h000000, ctrl_q} :
        (ap_addr == `JAD_OFS_CFG) ? {13'h0000, cfg_q} :
        (ap_addr == `JAD_OFS_STATUS) ? {19'h00000, status_w} :
        (ap_addr == `JAD_OFS_EVENT) ? {21'h000000, ev_q} :
        (ap_addr == `JAD_OFS_MASK) ? {21'h000000, mask_q} :
        (ap_addr == `JAD_OFS_BTHR) ? bthr_q : 32'h00000000;

    // ==========================================================
    // config fields
    wire logic sys_on = ctrl_q[`JAD_CTRL_SYS];
    wire logic det_on = ctrl_q[`JAD_CTRL_DET];
    wire logic [2:0] ins_sel = cfg_q[2:0];
    wire logic [1:0] rem_sel = cfg_q[4:3];
    wire logic [1:0] rate_sel = cfg_q[6:5];
    wire logic [1:0] tthr_sel = cfg_q[8:7];
    wire logic [1:0] hthr_sel = cfg_q[10:9];
    wire logic [7:0] btn_cfg = cfg_q[18:11];

    // ==========================================================
    // 1 ms tick
    wire logic tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));

    // ==========================================================
    // jack debounce
    wire logic run_det = sys_on & det_on;
    wire logic [9:0] ins_ms =
        (ins_sel == 3'h0) ? `JAD_INS_DEB0 :
        (ins_sel == 3'h1) ? `JAD_INS_DEB1 :
        (ins_sel == 3'h2) ? `JAD_INS_DEB2 :
        (ins_sel == 3'h3) ? `JAD_INS_DEB3 :
        (ins_sel == 3'h4) ? `JAD_INS_DEB4 :
        (ins_sel == 3'h5) ? `JAD_INS_DEB5 :
        (ins_sel == 3'h6) ? `JAD_INS_DEB6 : `JAD_INS_DEB7;
    wire logic [9:0] rem_ms =
        (rem_sel == 2'h0) ? `JAD_REM_DEB0 :
        (rem_sel == 2'h1) ? `JAD_REM_DEB1 :
        (rem_sel == 2'h2) ? `JAD_REM_DEB2 : `JAD_REM_DEB3;
    wire logic [9:0] deb_target = present_q ? rem_ms : ins_ms;
    wire logic level_new = run_det & (sense_q == JACK_SENSE) & (JACK_SENSE != present_q);
    wire logic deb_done = level_new & (deb_cnt_q >= deb_target);
    wire logic ins_ev = deb_done & JACK_SENSE;
    wire logic rem_ev = deb_done & ~JACK_SENSE;

    // ==========================================================
    // classification
    wire logic [13:0] type_thr =
        (tthr_sel == 2'h0) ? `JAD_TYPE_THR0 :
        (tthr_sel == 2'h1) ? `JAD_TYPE_THR1 :
        (tthr_sel == 2'h2) ? `JAD_TYPE_THR2 : `JAD_TYPE_THR3;
    wire logic [13:0] hp_thr =
        (hthr_sel == 2'h0) ? `JAD_HP_THR0 :
        (hthr_sel == 2'h1) ? `JAD_HP_THR1 :
        (hthr_sel == 2'h2) ? `JAD_HP_THR2 : `JAD_HP_THR3;
    wire logic type_meas = MEAS.res_ohm > type_thr;
    wire logic [9:0] lat3_ms = 10'(`JAD_LAT3_BASE_MS << rate_sel);
    wire logic [9:0] lat_ms = type_q ? 10'(lat3_ms << 1) : lat3_ms;
    wire logic lat_done = lat_cnt_q >= lat_ms;

    // ==========================================================
    // button polling
    wire logic [8:0] poll_ms =
        (btn_cfg >= `JAD_BTN_MAX_CFG) ? `JAD_BTN_MAX_MS :
        9'({btn_cfg, 1'b0});
    wire logic poll_on = (btn_cfg != 8'h00) & type_q;
    wire logic poll_due = poll_on & tick & (poll_cnt_q >= poll_ms - `JAD_BTN_MIN_MS + 9'd1);
    wire logic [7:0] bc = MEAS.btn_code;
    // one-hot {d, c, b, a}; all zero means no button
    wire logic [3:0] btn_cls =
        (bc < bthr_q[7:0]) ? 4'h1 :
        (bc < bthr_q[15:8]) ? 4'h8 :
        (bc < bthr_q[23:16]) ? 4'h2 :
        (bc < bthr_q[31:24]) ? 4'h4 : 4'h0;
    wire logic btn_take = (st_q == ST_BMEAS) & MEAS.btn_valid;
    // a held button masks every other press
    wire logic [3:0] press_ev = (btn_take & (held_q == 4'h0)) ? btn_cls : 4'h0;
    wire logic [3:0] rel_ev = (btn_take & (btn_cls == 4'h0)) ? held_q : 4'h0;

    // ==========================================================
    // state machine
    wire logic done_ev = (st_q == ST_LAT) & lat_done;
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (ins_ev) begin
                    st_d = ST_TYPE;
                end
            end
            ST_TYPE: begin
                if (!ctrl_q[`JAD_CTRL_TYPE_EN] || MEAS.res_valid) begin
                    st_d = ST_ORDER;
                end
            end
            ST_ORDER: begin
                if (!type_q || !ctrl_q[`JAD_CTRL_ORD_EN] || MEAS.order_valid) begin
                    st_d = ST_LAT;
                end
            end
            ST_LAT: begin
                if (lat_done) begin
                    st_d = ST_BTN;
                end
            end
            ST_BTN: begin
                if (poll_due) begin
                    st_d = ST_BMEAS;
                end
            end
            ST_BMEAS: begin
                if (MEAS.btn_valid) begin
                    st_d = ST_BTN;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (rem_ev || !present_q && st_q != ST_IDLE) begin
            st_d = ST_IDLE;
        end
    end

    // ==========================================================
    // events, mask and interrupt
    wire logic [10:0] ev_set = {rel_ev, press_ev, done_ev, rem_ev, ins_ev};
    wire logic [10:0] ev_clr = wr_ev ? HWDATA[10:0] : 11'h000;
    // a set in the clearing cycle survives
    wire logic [10:0] ev_d = (ev_q & ~ev_clr) | ev_set;

    // ==========================================================
    // mic supply
    wire logic mic_on = present_q & (mic_auto_q | ctrl_q[`JAD_CTRL_MIC]);

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = rdata_q;
    assign IRQ = |(ev_q & ~mask_q);
    assign MEAS_REQ.type_req = (st_q == ST_TYPE) & ctrl_q[`JAD_CTRL_TYPE_EN];
    assign MEAS_REQ.order_req = (st_q == ST_ORDER) & type_q & ctrl_q[`JAD_CTRL_ORD_EN];
    assign MEAS_REQ.btn_req = (st_q == ST_BMEAS);
    assign MIC_SUPPLY_ENABLE = mic_on;
    assign MIC_ISOLATE = ~mic_on;
    assign MIC_DISCHARGE = dis_q;

    // ==========================================================
    // bus registers
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            dp_addr_q <= 8'h00;
            dp_wr_q <= 1'b0;
            rdata_q <= 32'h00000000;
            ctrl_q <= `JAD_CTRL_RST;
            cfg_q <= `JAD_CFG_RST;
            mask_q <= `JAD_MASK_RST;
            bthr_q <= `JAD_BTHR_RST;
        end else begin
            dp_addr_q <= ap_addr;
            dp_wr_q <= ap_valid & HWRITE & addr_hi_ok;
            if (ap_valid && !HWRITE) begin
                rdata_q <= rd_mux;
            end
            if (wr_ctrl) begin
                ctrl_q <= HWDATA[7:0];
            end else if (rem_ev) begin
                ctrl_q[`JAD_CTRL_MIC] <= 1'b0;
            end
            if (wr_cfg) begin
                cfg_q <= HWDATA[18:0];
            end
            if (wr_mask) begin
                mask_q <= HWDATA[10:0];
            end
            if (wr_bthr) begin
                bthr_q <= HWDATA;
            end
        end
    end

    // ==========================================================
    // timers
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            tick_cnt_q <= 16'h0000;
            sense_q <= 1'b0;
            deb_cnt_q <= 10'h000;
            lat_cnt_q <= 10'h000;
            poll_cnt_q <= 9'h000;
        end else begin
            tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
            sense_q <= JACK_SENSE;
            if (!run_det || sense_q != JACK_SENSE || deb_done) begin
                deb_cnt_q <= 10'h000;
            end else if (tick && deb_cnt_q != 10'h3FF) begin
                deb_cnt_q <= deb_cnt_q + 10'h001;
            end
            if (st_q == ST_IDLE) begin
                lat_cnt_q <= 10'h000;
            end else if (tick && lat_cnt_q != 10'h3FF) begin
                lat_cnt_q <= lat_cnt_q + 10'h001;
            end
            if (st_q != ST_BTN || poll_due) begin
                poll_cnt_q <= 9'h000;
            end else if (tick && poll_cnt_q != 9'h1FF) begin
                poll_cnt_q <= poll_cnt_q + 9'h001;
            end
        end
    end

    // ==========================================================
    // detection state and results
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            st_q <= ST_IDLE;
            present_q <= 1'b0;
            ev_q <= 11'h000;
            type_q <= 1'b0;
            order_q <= 1'b0;
            hp_q <= 1'b0;
            mic_auto_q <= 1'b0;
            mic_up_q <= 1'b0;
            dis_q <= 1'b0;
            btn_code_q <= 8'h00;
            held_q <= 4'h0;
        end else begin
            st_q <= st_d;
            ev_q <= ev_d;
            dis_q <= rem_ev;
            mic_up_q <= mic_on & MIC_RAIL_OK;
            if (ins_ev) begin
                present_q <= 1'b1;
            end else if (rem_ev) begin
                present_q <= 1'b0;
            end
            if (st_q == ST_TYPE) begin
                if (!ctrl_q[`JAD_CTRL_TYPE_EN]) begin
                    type_q <= ctrl_q[`JAD_CTRL_TYPE_FRC];
                end else if (MEAS.res_valid) begin
                    type_q <= type_meas;
                end
            end
            if (st_q == ST_ORDER) begin
                if (!ctrl_q[`JAD_CTRL_ORD_EN]) begin
                    order_q <= ctrl_q[`JAD_CTRL_ORD_FRC];
                end else if (MEAS.order_valid) begin
                    order_q <= ~MEAS.order_sleeve_mic;
                end
            end
            if (ctrl_q[`JAD_CTRL_HP_EN] && MEAS.load_valid) begin
                hp_q <= MEAS.load_ohm >= hp_thr;
            end
            if (rem_ev) begin
                mic_auto_q <= 1'b0;
            end else if (done_ev && type_q) begin
                mic_auto_q <= 1'b1;
            end
            if (rem_ev) begin
                held_q <= 4'h0;
            end else if (btn_take) begin
                btn_code_q <= bc;
                if (held_q == 4'h0) begin
                    held_q <= btn_cls;
                end else if (btn_cls == 4'h0) begin
                    held_q <= 4'h0;
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: jad_accessory_detect_assertions.sv
// checker on the accessory detector's ports
`timescale 1ns/1ps
`default_nettype none
module jad_accessory_detect_assertions #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic JACK_SENSE,
    input wire jad_pkg::jad_meas_s MEAS,
    input wire jad_pkg::jad_req_s MEAS_REQ,
    input wire logic MIC_SUPPLY_ENABLE,
    input wire logic MIC_DISCHARGE,
    input wire logic MIC_ISOLATE,
    input wire logic IRQ
);
    import jad_pkg::*;
    // ==========================================================
    // bus phase tracking
    wire rd_take = HSEL && HREADY && HTRANS[1] && !HWRITE;
    wire wr_dp_d = RST_B && HSEL && HREADY && HTRANS[1] && HWRITE;
    logic wr_dp_q;
    always_ff @(posedge CLK) wr_dp_q <= wr_dp_d;
    default clocking dcb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // a removal aborts a pending request, so only a jack held in counts
    sequence s_type_wait;
        MEAS_REQ.type_req && !MEAS.res_valid && JACK_SENSE;
    endsequence
    sequence s_order_wait;
        MEAS_REQ.order_req && !MEAS.order_valid && JACK_SENSE;
    endsequence
    sequence s_btn_wait;
        MEAS_REQ.btn_req && !MEAS.btn_valid && JACK_SENSE;
    endsequence
    // ==========================================================
    // properties
    bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus answer not okay");
    rdata_hold_a: assert property (!rd_take |=> $stable(HRDATA))
        else $error("read data moved without a read");
    // only a register write may drop the line
    irq_clear_a: assert property ($fell(IRQ) |-> $past(wr_dp_q))
        else $error("interrupt dropped without a host write");
    isolate_inverse_a: assert property (MIC_ISOLATE == !MIC_SUPPLY_ENABLE)
        else $error("mic isolation not opposite to supply");
    discharge_pulse_a: assert property (MIC_DISCHARGE |-> !MIC_SUPPLY_ENABLE ##1 !MIC_DISCHARGE)
        else $error("discharge not a single pulse with supply off");
    discharge_removal_a: assert property (MIC_DISCHARGE |-> !$past(JACK_SENSE, 2))
        else $error("discharge without the jack out");
    type_req_hold_a: assert property (s_type_wait |=> MEAS_REQ.type_req)
        else $error("type request dropped before its answer");
    order_req_hold_a: assert property (s_order_wait |=> MEAS_REQ.order_req)
        else $error("order request dropped before its answer");
    btn_req_hold_a: assert property (s_btn_wait |=> MEAS_REQ.btn_req)
        else $error("button request dropped before its answer");
    req_exclusive_a: assert property (MEAS_REQ.type_req |-> !MEAS_REQ.order_req)
        else $error("type and order measured at once");
endmodule
bind jad_accessory_detect jad_accessory_detect_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .JACK_SENSE(JACK_SENSE), .MEAS(MEAS), .MEAS_REQ(MEAS_REQ),
    .MIC_SUPPLY_ENABLE(MIC_SUPPLY_ENABLE), .MIC_DISCHARGE(MIC_DISCHARGE),
    .MIC_ISOLATE(MIC_ISOLATE), .IRQ(IRQ));
`default_nettype wire

// File: jad_front_model.sv
// behavioural accessory and analog front end answering measurement requests
`timescale 1ns/1ps
`default_nettype none
module jad_front_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire jad_pkg::jad_req_s req,
    input wire logic slow,
    input wire logic [13:0] res_ohm,
    input wire logic sleeve_mic,
    input wire logic [13:0] load_ohm,
    input wire logic [7:0] btn_code,
    input wire logic supply_en,
    output jad_pkg::jad_meas_s meas,
    output logic rail_ok
);
    import jad_pkg::*;
    logic [3:0] wait_q;
    logic [3:0] load_q;
    logic tv_q, ov_q, bv_q;
    wire any_req = req.type_req || req.order_req || req.btn_req;
    wire busy = tv_q || ov_q || bv_q;
    wire fire = any_req && !busy && wait_q == (slow ? 4'h7 : 4'h1);
    wire lv = &load_q;
    always_ff @(posedge clk) begin
        wait_q <= (!rst_b || !any_req || fire || busy) ? 4'h0 : wait_q + 4'h1;
        tv_q <= rst_b && fire && req.type_req;
        ov_q <= rst_b && fire && !req.type_req && req.order_req;
        bv_q <= rst_b && fire && !req.type_req && !req.order_req && req.btn_req;
        load_q <= rst_b ? load_q + 4'h1 : 4'h0;
        rail_ok <= rst_b && supply_en;
    end
    // outside its valid cycle a field carries junk, never the answer
    assign meas = '{res_valid: tv_q, res_ohm: tv_q ? res_ohm : ~res_ohm,
        order_valid: ov_q, order_sleeve_mic: ov_q ? sleeve_mic : ~sleeve_mic,
        load_valid: lv, load_ohm: lv ? load_ohm : ~load_ohm,
        btn_valid: bv_q, btn_code: bv_q ? btn_code : ~btn_code};
endmodule
`default_nettype wire

// File: jad_accessory_detect_tb.sv
// self-checking bench for the jack accessory detector
`timescale 1ns/1ps
`default_nettype none
`include "jad_params.svh"
module jad_accessory_detect_tb;
    import jad_pkg::*;
    localparam int TICK = 10;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic jack = 1'b1;
    logic slow = 1'b1;
    logic [13:0] res_ohm = 14'h320;
    logic [13:0] load_ohm = 14'h7D0;
    logic [7:0] btn = 8'hFF;
    logic [7:0] codes [3] = '{8'h50, 8'h90, 8'hFF};
    logic [31:0] hrdata;
    logic hreadyout, hresp, rail_ok, supply_en, isolate, irq;
    jad_meas_s meas;
    jad_req_s req;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int t0;
    initial forever #10 clk = ~clk;
    jad_accessory_detect #(.TICK_CYCLES(TICK)) i_dut (.CLK(clk), .RST_B(rst_b), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .JACK_SENSE(jack), .MIC_RAIL_OK(rail_ok), .MEAS(meas), .MEAS_REQ(req),
        .MIC_SUPPLY_ENABLE(supply_en), .MIC_DISCHARGE(), .MIC_ISOLATE(isolate), .IRQ(irq));
    jad_front_model i_front (.clk(clk), .rst_b(rst_b), .req(req), .slow(slow),
        .res_ohm(res_ohm), .sleeve_mic(1'b1), .load_ohm(load_ohm), .btn_code(btn),
        .supply_en(supply_en), .meas(meas), .rail_ok(rail_ok));
    // ==========================================================
    // checking and bus tasks
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] m,
        input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk_reg(nm, e, q & m);
    endtask
    // ends on a falling edge so outputs have settled
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (irq !== 1'b1 && n < 2000);
        chk_pin("irq raised", 1'b1, irq);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // tests
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        wr(32'h100, 32'hFFFFFFFF);
        rd_chk("unmapped", 32'h100, 32'hFFFFFFFF, 32'h0);
        rd_chk("ctrl", `JAD_OFS_CTRL, 32'hFF, 32'h14);
        rd_chk("cfg", `JAD_OFS_CFG, 32'h7FFFF, 32'h82);
        rd_chk("mask", `JAD_OFS_MASK, 32'h7FF, 32'h0);
        rd_chk("bthr", `JAD_OFS_BTHR, 32'hFFFFFFFF, 32'hC0804000);
        wr(`JAD_OFS_STATUS, 32'hFFFFFFFF);
        rd_chk("event idle", `JAD_OFS_EVENT, 32'h7FF, 32'h0);
        rd_chk("status idle", `JAD_OFS_STATUS, 32'h17, 32'h0);
        $display("test reset done");
        wr(`JAD_OFS_CFG, 32'h87);
        wr(`JAD_OFS_CTRL, 32'h17);
        wait_irq();
        t0 = cyc;
        rd_chk("insert ev", `JAD_OFS_EVENT, 32'h7FF, 32'h1);
        wr(`JAD_OFS_EVENT, 32'h0);
        rd_chk("write zero", `JAD_OFS_EVENT, 32'h7FF, 32'h1);
        wr(`JAD_OFS_EVENT, 32'h1);
        wait_cyc(1);
        chk_pin("irq cleared", 1'b0, irq);
        wait_irq();
        chk_pin("latency", 1'b1, (cyc - t0) inside {[64 * TICK - 15:64 * TICK + 15]});
        rd_chk("complete ev", `JAD_OFS_EVENT, 32'h7FF, 32'h4);
        rd_chk("four pole", `JAD_OFS_STATUS, 32'h17, 32'h13);
        wait_cyc(1);
        chk_pin("supply on", 1'b1, supply_en);
        $display("test auto detect done");
        slow <= 1'b0;
        wr(`JAD_OFS_CFG, 32'hA87);
        wr(`JAD_OFS_CTRL, 32'h57);
        for (int k = 0; k < 2; k++) begin
            load_ohm <= k ? 14'hBB8 : 14'h7D0;
            wait_cyc(40);
            rd_chk("load", `JAD_OFS_STATUS, 32'h8, k << 3);
        end
        foreach (codes[i]) begin
            btn <= codes[i];
            wait_cyc(60);
        end
        rd_chk("buttons", `JAD_OFS_EVENT, 32'h7FF, 32'h114);
        rd_chk("last code", `JAD_OFS_STATUS, 32'h1FE0, 32'h1FE0);
        $display("test load and buttons done");
        wr(`JAD_OFS_MASK, 32'h7FF);
        jack <= 1'b0;
        wait_cyc(40);
        chk_pin("irq masked", 1'b0, irq);
        chk_pin("supply off", 1'b0, supply_en);
        chk_pin("isolated", 1'b1, isolate);
        rd_chk("remove ev", `JAD_OFS_EVENT, 32'h7FF, 32'h116);
        rd_chk("absent", `JAD_OFS_STATUS, 32'h1, 32'h0);
        wr(`JAD_OFS_EVENT, 32'h7FF);
        wr(`JAD_OFS_MASK, 32'h0);
        $display("test removal done");
        res_ohm <= 14'h064;
        for (int k = 0; k < 2; k++) begin
            wr(`JAD_OFS_CTRL, 32'h3 | (k << 3) | (k << 5));
            jack <= 1'b1;
            wait_irq();
            wr(`JAD_OFS_EVENT, 32'h1);
            wait_irq();
            rd_chk("forced", `JAD_OFS_STATUS, 32'h7, 32'h1 | (k << 1) | (k << 2));
            wr(`JAD_OFS_EVENT, 32'h7FF);
            jack <= 1'b0;
            wait_cyc(40);
            wr(`JAD_OFS_EVENT, 32'h7FF);
        end
        $display("test forced done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
